// ==== rtl/pmc_pkg.sv ====
/*
  Shared constants for the switch power mode controller: mode codes, field
  positions, host addresses and timing counts.
  Assumes a 125 MHz core clock.
*/
package pmc_pkg;
  // Global mode codes, two-bit field
  localparam logic [1:0] MODE_NORM  = 2'h0;
  localparam logic [1:0] MODE_ED    = 2'h1;
  localparam logic [1:0] MODE_SPD   = 2'h2;
  localparam logic [1:0] MODE_PS    = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_NORM;

  // Host register addresses and field positions
  localparam logic [7:0] MODE_REG_ADDR   = 8'h0e;
  localparam int         MODE_FIELD_LSB  = 3;
  localparam int         MODE_FIELD_MSB  = 4;
  localparam int         PORT_CTL13_BASE = 29;
  localparam int         PORT_CTL_STRIDE = 16;
  localparam int         PORT_PD_BIT     = 3;
  localparam logic       PORT_PD_RESET   = 1'h0;
  localparam int         MAX_PORTS       = 5;

  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CHIP_RST_NS    = 80;
  localparam int CHIP_RST_CYC   = (CHIP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W      = $clog2(CHIP_RST_CYC + 1);
  localparam int SLEEP_TICK_NS  = 1000;
  localparam int SLEEP_TICK_CYC = SLEEP_TICK_NS / CLK_PERIOD_NS;
  localparam int GO_SLEEP_W     = 8;
endpackage

// ==== rtl/pmc_timer_if.sv ====
/*
  Link between the mode controller and its go-sleep timer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface pmc_timer_if;
  logic                         arm;    // Energy detect watch active
  logic                         energy; // Synchronised cable energy, any port
  logic [pmc_pkg::GO_SLEEP_W-1:0] limit; // Go-sleep time in ticks
  logic                         expire; // Idle time passed the limit

  modport ctl (output arm, output energy, output limit, input expire);
  modport tmr (input arm, input energy, input limit, output expire);
endinterface

// ==== rtl/pmc_sleep_timer.sv ====
/*
  Go-sleep timer: counts idle ticks while armed and no energy is seen.
  Assumes inputs already synchronised and reset released synchronously.
*/
`timescale 1ns/1ps
module pmc_sleep_timer #(
  parameter int TICK_CYC = pmc_pkg::SLEEP_TICK_CYC
) (
  input  wire logic  clk,   // Core clock
  input  wire logic  rst_b, // Synchronised reset, active low
  pmc_timer_if.tmr   tif    // Timer link
);
  import pmc_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  if (TICK_CYC < 1) begin : g_chk
    $error("pmc_sleep_timer: TICK_CYC must be at least one");
  end

  logic [TICK_W-1:0]     tick_ff;
  logic [GO_SLEEP_W:0]   idle_ff;
  logic                  expire_ff;
  wire                   hold  = !tif.arm || tif.energy;
  wire                   tick  = (tick_ff == TICK_LAST);
  wire                   sat   = idle_ff[GO_SLEEP_W];
  wire [GO_SLEEP_W:0]    nxt_idle = hold ? '0 : (tick && !sat) ? idle_ff + 1'h1 : idle_ff;

  // Any energy restarts the idle window, so a sleep needs one unbroken quiet stretch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff   <= '0;
      idle_ff   <= '0;
      expire_ff <= 1'h0;
    end else begin
      tick_ff   <= (hold || tick) ? '0 : tick_ff + 1'h1;
      idle_ff   <= nxt_idle;
      expire_ff <= !hold && (nxt_idle > {1'h0, tif.limit});
    end
  end

  assign tif.expire = expire_ff;
endmodule

// ==== rtl/pmc_top.sv ====
/*
  Switch power mode controller: hardware power-down, global mode field,
  per-port PHY power-down, clock and block gating, internal chip reset.
  Assumes host accesses arrive as one-cycle strobes on the core clock,
  while the power-down and energy pins are asynchronous.
*/
`timescale 1ns/1ps
module pmc_top #(
  parameter int NUM_PORTS = pmc_pkg::MAX_PORTS
) (
  input  wire logic                              clk,             // Core clock
  input  wire logic                              rst_b,           // Async reset, active low
  input  wire logic                              hw_powerdown_n,  // Power-down pin, low
  input  wire logic [NUM_PORTS-1:0]              port_energy,     // Cable energy pins
  input  wire logic [NUM_PORTS-1:0]              an_enable,       // Autonegotiation on
  input  wire logic [pmc_pkg::GO_SLEEP_W-1:0]    go_sleep_time,   // Idle ticks to sleep
  input  wire logic                              host_wr,         // Host write strobe
  input  wire logic                              host_rd,         // Host read strobe
  input  wire logic [7:0]                        host_addr,       // Host address
  input  wire logic [7:0]                        host_wdata,      // Host write data
  output logic      [1:0]                        global_mode,     // Current mode field
  output logic                                   pll_clk_en,      // PLL clocks enable
  output logic                                   mac_en,          // MAC enable
  output logic                                   host_if_en,      // Host interface enable
  output logic      [NUM_PORTS-1:0]              phy_en,          // PHY power enable
  output logic      [NUM_PORTS-1:0]              phy_rx_full_en,  // Full receiver enable
  output logic                                   phy_ed_only,     // Energy detect only
  output logic                                   chip_rst_n       // Internal reset, low
);
  import pmc_pkg::*;

  if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_chk
    $error("pmc_top: NUM_PORTS must be 1 to 5");
  end

  typedef enum logic [1:0] {ST_HWPD, ST_RST, ST_RUN} pmc_state_e;

  localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(CHIP_RST_CYC - 1);

  logic                     rst_meta_ff;
  logic                     rst_sync_ff;
  logic [NUM_PORTS:0]       pin_meta_ff;
  logic [NUM_PORTS:0]       pin_sync_ff;
  pmc_state_e               st_ff;
  pmc_state_e               nxt_st;
  logic [RST_CNT_W-1:0]     rst_cnt_ff;
  logic [1:0]               mode_ff;
  logic [NUM_PORTS-1:0]     port_pd_ff;
  logic                     ed_low_ff;
  logic                     pll_ff;
  logic                     mac_ff;
  logic                     host_ff;
  logic [NUM_PORTS-1:0]     phy_ff;
  logic [NUM_PORTS-1:0]     rx_full_ff;
  logic                     ed_only_ff;
  logic                     chip_rst_n_ff;
  pmc_timer_if              tif ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'h0;
      rst_sync_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {hw_powerdown_n, port_energy};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Pin and mode decode
  wire                 pd_n_s   = pin_sync_ff[NUM_PORTS];
  wire [NUM_PORTS-1:0] energy_s = pin_sync_ff[NUM_PORTS-1:0];
  wire                 run      = (st_ff == ST_RUN);
  wire                 is_norm  = (mode_ff == MODE_NORM);
  wire                 is_ed    = (mode_ff == MODE_ED);
  wire                 is_spd   = (mode_ff == MODE_SPD);
  wire                 is_ps    = (mode_ff == MODE_PS);
  wire                 host_acc = host_wr || host_rd;
  // Host interface is dark in energy sleep, so writes only land when awake
  wire                 wr_ok    = run && (is_norm || is_ps || (is_ed && !ed_low_ff));
  wire                 mode_hit = wr_ok && host_wr && (host_addr == MODE_REG_ADDR);
  wire [1:0]           wr_mode  = host_wdata[MODE_FIELD_MSB:MODE_FIELD_LSB];
  wire                 spd_wake = run && is_spd && host_acc;

  // Saving acts per port only with autonegotiation on and no cable energy
  wire [NUM_PORTS-1:0] ps_port  = {NUM_PORTS{is_ps}} & an_enable & ~energy_s;
  wire                 phy_on   = run && (is_norm || is_ps || (is_ed && !ed_low_ff));

  // Block gating decode from state and mode
  wire                 nxt_pll  = (st_ff == ST_RST) || (run && (is_norm || is_ps));
  wire                 nxt_blk  = run && (is_norm || is_ps);
  wire [NUM_PORTS-1:0] nxt_phy  = phy_on ? ~port_pd_ff : '0;
  wire [NUM_PORTS-1:0] nxt_rxf  = nxt_phy & ~ps_port;
  wire                 nxt_edo  = run && is_ed && ed_low_ff;

  // State sequencing; the power-down pin outranks everything
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_HWPD: begin
        if (pd_n_s) begin
          nxt_st = ST_RST;
        end
      end
      ST_RST: begin
        if (rst_cnt_ff == '0) begin
          nxt_st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (spd_wake) begin
          nxt_st = ST_RST;
        end
      end
      default: nxt_st = ST_HWPD;
    endcase
    if (!pd_n_s) begin
      nxt_st = ST_HWPD;
    end
  end

  // Sequencer and reset counter
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff      <= ST_HWPD;
      rst_cnt_ff <= RST_LOAD;
    end else begin
      st_ff      <= nxt_st;
      rst_cnt_ff <= (st_ff == ST_RST) ? rst_cnt_ff - 1'h1 : RST_LOAD;
    end
  end

  // Mode field; any internal reset returns it to normal
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mode_ff <= MODE_RESET;
    end else if (!run) begin
      mode_ff <= MODE_RESET;
    end else if (mode_hit) begin
      mode_ff <= wr_mode;
    end
  end

  // Per-port power-down bits, one control register per port
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    wire port_hit = wr_ok && host_wr
                    && (host_addr == 8'(PORT_CTL13_BASE + PORT_CTL_STRIDE * i));
    always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
        port_pd_ff[i] <= PORT_PD_RESET;
      end else if (!run) begin
        port_pd_ff[i] <= PORT_PD_RESET;
      end else if (port_hit) begin
        port_pd_ff[i] <= host_wdata[PORT_PD_BIT];
      end
    end
  end

  // Energy detect sleep flag; energy wakes, set only without energy
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ed_low_ff <= 1'h0;
    end else if (!run || !is_ed || (|energy_s)) begin
      ed_low_ff <= 1'h0;
    end else if (tif.expire) begin
      ed_low_ff <= 1'h1;
    end
  end

  assign tif.arm    = run && is_ed && !ed_low_ff;
  assign tif.energy = |energy_s;
  assign tif.limit  = go_sleep_time;

  pmc_sleep_timer #(
    .TICK_CYC (SLEEP_TICK_CYC)
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_sync_ff),
    .tif   (tif.tmr)
  );

  // Registered outputs; all but the PLL enable held in reset until the sequencer runs, PLL enable already on in ST_RST
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pll_ff        <= 1'h0;
      mac_ff        <= 1'h0;
      host_ff       <= 1'h0;
      phy_ff        <= '0;
      rx_full_ff    <= '0;
      ed_only_ff    <= 1'h0;
      chip_rst_n_ff <= 1'h0;
    end else begin
      pll_ff        <= nxt_pll;
      mac_ff        <= nxt_blk;
      host_ff       <= nxt_blk;
      phy_ff        <= nxt_phy;
      rx_full_ff    <= nxt_rxf;
      ed_only_ff    <= nxt_edo;
      chip_rst_n_ff <= run;
    end
  end

  assign global_mode    = mode_ff;
  assign pll_clk_en     = pll_ff;
  assign mac_en         = mac_ff;
  assign host_if_en     = host_ff;
  assign phy_en         = phy_ff;
  assign phy_rx_full_en = rx_full_ff;
  assign phy_ed_only    = ed_only_ff;
  assign chip_rst_n     = chip_rst_n_ff;

  // Checks
  sequence s_pd_held;
    !pd_n_s ##1 !pd_n_s;
  endsequence
  sequence s_rst_pulse;
    (!chip_rst_n_ff) [*8];
  endsequence

  AST_HWPD_OFF: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    s_pd_held |=> !pll_ff && !mac_ff && !host_ff && (phy_ff == '0) && !chip_rst_n_ff)
    else $error("power-down pin did not turn blocks off");
  AST_RELEASE_RST: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (st_ff == ST_HWPD && pd_n_s) |=> s_rst_pulse)
    else $error("no internal reset after power-down release");
  AST_SPD_DECODE: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (run && is_spd && !host_acc && pd_n_s) |=> !mac_ff && !host_ff && !pll_ff && phy_ff == '0)
    else $error("soft power-down left a block on");
  AST_PORT_PD: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    port_pd_ff[0] |=> !phy_ff[0])
    else $error("port power-down ignored");
  AST_PLL_GATE: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (run && (is_ed || is_spd)) |=> !pll_ff)
    else $error("PLL left on in low power mode");
  AST_PS_GATE: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (run && ps_port[0] && !port_pd_ff[0]) |=> mac_ff && host_ff && phy_ff[0] && !rx_full_ff[0])
    else $error("power saving gating wrong");
  AST_RST_NORMAL: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (st_ff == ST_RST) |=> (mode_ff == MODE_NORM) && port_pd_ff == '0 && pll_ff)
    else $error("reset did not restore normal mode");
  AST_MODE_WR: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (mode_hit && !spd_wake && pd_n_s) |=> mode_ff == $past(wr_mode))
    else $error("mode write not taken");
  AST_SPD_WAKE: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (spd_wake && pd_n_s) |=> (st_ff == ST_RST) ##1 !chip_rst_n_ff ##[1:20] chip_rst_n_ff)
    else $error("soft power-down wake failed");
  AST_ED_WAKE: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (ed_low_ff && (|energy_s)) |=> !ed_low_ff ##1 !ed_only_ff)
    else $error("energy did not wake from sleep");
endmodule

// ==== bench/tb.sv ====
/*
  Self-checking bench for the switch power mode controller top.
  Assumes pmc_top with default ports and 1 us go-sleep ticks of 125 clocks.
*/
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  logic       clk;
  logic       rst_b;
  logic       hw_powerdown_n;
  logic [4:0] port_energy;
  logic [4:0] an_enable;
  logic [7:0] go_sleep_time;
  logic       host_wr;
  logic       host_rd;
  logic [7:0] host_addr;
  logic [7:0] host_wdata;
  logic [1:0] global_mode;
  logic       pll_clk_en;
  logic       mac_en;
  logic       host_if_en;
  logic [4:0] phy_en;
  logic [4:0] phy_rx_full_en;
  logic       phy_ed_only;
  logic       chip_rst_n;
  int         fails;
  int         checked;
  int         cycles;
  wire  [9:0] st = {global_mode, pll_clk_en, mac_en, host_if_en, phy_en};

  pmc_top uut (.clk(clk), .rst_b(rst_b), .hw_powerdown_n(hw_powerdown_n),
    .port_energy(port_energy), .an_enable(an_enable), .go_sleep_time(go_sleep_time),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .global_mode(global_mode), .pll_clk_en(pll_clk_en), .mac_en(mac_en),
    .host_if_en(host_if_en), .phy_en(phy_en), .phy_rx_full_en(phy_rx_full_en),
    .phy_ed_only(phy_ed_only), .chip_rst_n(chip_rst_n));

  // 125 MHz core clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Counts: checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Expected gating word for a mode with no port powered down; soft power-down expects every PHY off
  function automatic logic [9:0] exp_st(input logic [1:0] m);
    logic on;
    on = (m == MODE_NORM) || (m == MODE_PS);
    return {m, on, on, on, (m == MODE_SPD) ? 5'h00 : 5'h1f};
  endfunction

  // One-cycle host write strobe, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host_wr    = 1'h1;
    host_addr  = a;
    host_wdata = d;
    @(negedge clk);
    host_wr = 1'h0;
  endtask

  // Bounded wait for the internal reset to finish
  task automatic wait_run();
    int n;
    n = 0;
    while (chip_rst_n !== 1'h1 && n < 200) begin
      tick(1);
      n++;
    end
    chk({15'h0, chip_rst_n}, 16'h1);
  endtask

  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      wr(MODE_REG_ADDR, {3'h0, 2'(m), 3'h0});
      tick(3);
      chk({6'h0, st}, {6'h0, exp_st(2'(m))});
      if (2'(m) == MODE_SPD) begin
        tick(1);
        host_rd = 1'h1;
        tick(1);
        host_rd = 1'h0;
        tick(1);
        chk({13'h0, chip_rst_n, global_mode}, 16'h0);
        wait_run();
      end else begin
        wr(MODE_REG_ADDR, 8'h00);
        tick(3);
      end
      chk({6'h0, st}, {6'h0, exp_st(MODE_NORM)});
    end
    $display("test modes done");
  endtask

  task automatic t_port_pd();
    for (int i = 0; i < 5; i++) begin
      wr(8'(PORT_CTL13_BASE + PORT_CTL_STRIDE * i), 8'h08);
      tick(3);
      chk({11'h0, phy_en}, {11'h0, 5'h1f & ~(5'h01 << i)});
      wr(8'(PORT_CTL13_BASE + PORT_CTL_STRIDE * i), 8'h00);
      tick(3);
      chk({11'h0, phy_en}, 16'h001f);
    end
    $display("test port power-down done");
  endtask

  task automatic t_saving();
    wr(MODE_REG_ADDR, 8'h18);
    an_enable   = 5'h1f;
    port_energy = 5'h0a;
    tick(6);
    chk({11'h0, phy_rx_full_en}, 16'h000a);
    an_enable = 5'h00;
    tick(4);
    chk({11'h0, phy_rx_full_en}, 16'h001f);
    port_energy = 5'h1f;
    wr(MODE_REG_ADDR, 8'h00);
    tick(3);
    $display("test power saving done");
  endtask

  task automatic t_energy();
    int n;
    wr(MODE_REG_ADDR, 8'h08);
    port_energy = 5'h00;
    n = 0;
    // Two ticks of limit: sleep must come within a few microseconds
    while (phy_ed_only !== 1'h1 && n < 1500) begin
      tick(1);
      n++;
    end
    chk({10'h0, phy_ed_only, phy_en}, 16'h0020);
    chk({15'h0, n > 250}, 16'h1);
    // Limit of two ticks means sleep on the third idle tick, not much later
    chk({15'h0, n < 4 * SLEEP_TICK_CYC}, 16'h1);
    port_energy = 5'h04;
    tick(8);
    chk({10'h0, phy_ed_only, phy_en}, 16'h001f);
    port_energy = 5'h1f;
    wr(MODE_REG_ADDR, 8'h00);
    tick(3);
    chk({6'h0, st}, {6'h0, exp_st(MODE_NORM)});
    $display("test energy detect done");
  endtask

  task automatic t_hw_pd();
    wr(MODE_REG_ADDR, 8'h18);
    hw_powerdown_n = 1'h0;
    tick(8);
    chk({5'h0, st, chip_rst_n}, 16'h0);
    hw_powerdown_n = 1'h1;
    tick(5);
    chk({15'h0, chip_rst_n}, 16'h0);
    wait_run();
    chk({6'h0, st}, {6'h0, exp_st(MODE_NORM)});
    $display("test hardware power-down done");
  endtask

  // Main sequence
  initial begin
    fails          = 0;
    checked        = 0;
    cycles         = 0;
    rst_b          = 1'h0;
    hw_powerdown_n = 1'h1;
    port_energy    = 5'h1f;
    an_enable      = 5'h00;
    go_sleep_time  = 8'h02;
    host_wr        = 1'h0;
    host_rd        = 1'h0;
    host_addr      = 8'h00;
    host_wdata     = 8'h00;
    tick(3);
    rst_b = 1'h1;
    wait_run();
    chk({6'h0, st}, {6'h0, exp_st(MODE_NORM)});
    $display("test reset done");
    t_modes();
    t_port_pd();
    t_saving();
    t_energy();
    t_hw_pd();
    end_of_test();
  end
endmodule
